// *** bench/tb_timer16_interval_pwm_capture.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tmd_regs.svh"
module tb_timer16_interval_pwm_capture
  import tmd_pkg::*;
;
  logic       clock, rst, reg_wr, reg_rd, irq_ack, ext_pin, cap_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_ack_vector;
  logic       tog, pwm, lvl, ovf, mci;
  int         err_total, n_checks, n;
  logic [15:0] lfsr_q, c, v, d;
  logic [7:0]  b;
  int          divs [5] = '{1024, 256, 64, 8, 1};

  tmd_timer16 u_dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_count_clock_pin(ext_pin), .capture_input_pin(cap_pin),
    .irq_ack(irq_ack), .irq_ack_vector(irq_ack_vector),
    .toggle_output_pin(tog), .pwm_output_pin(pwm), .shared_irq_level(lvl),
    .overflow_irq(ovf), .match_capture_irq(mci)
  );

  always #4 clock = ~clock;

  // ==========================================
  // helpers
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string w);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string w);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %b want %b", $time, w, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(posedge clock);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= dv;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clock);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // hi byte first: the low write commits the buffered pair
  task automatic wr16(input logic [7:0] a, input logic [15:0] dv);
    wr(a, dv[15:8]);
    wr(a + 8'h01, dv[7:0]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] q);
    rd(a, q[15:8]);
    rd(a + 8'h01, q[7:0]);
  endtask
  task automatic ctl(input logic [2:0] ck, input logic [1:0] m, input logic [2:0] low);
    wr(`TMD_CONTROL_OFF, {ck, m, low});
  endtask
  task automatic pulse(input bit cap);
    @(posedge clock);
    if (cap) cap_pin <= 1'b1; else ext_pin <= 1'b1;
    cyc(6);
    if (cap) cap_pin <= 1'b0; else ext_pin <= 1'b0;
    cyc(6);
  endtask
  task automatic ack(input logic [7:0] vec);
    @(posedge clock);
    irq_ack <= 1'b1; irq_ack_vector <= vec;
    @(posedge clock);
    irq_ack <= 1'b0;
    cyc(2);
  endtask
  task automatic wait_tog(output int k);
    logic t;
    t = tog;
    k = 0;
    do begin @(posedge clock); #1; k++; end while (tog === t && k < 300);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================
  // watchdog: about 90k cycles of tests, margin on top
  initial begin
    repeat (99000) @(posedge clock);
    err_total++;
    final_report();
  end

  // ==========================================
  // main sequence
  initial begin
    clock = 0; rst = 1; reg_wr = 0; reg_rd = 0; irq_ack = 0; ext_pin = 0; cap_pin = 0;
    reg_addr = 0; reg_wdata = 0; irq_ack_vector = 0; lfsr_q = 16'h0032;
    err_total = 0; n_checks = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    cyc(4);
    rd(`TMD_CONTROL_OFF, b); chk16({8'h00, b}, 16'h0000, "control reset");
    rd16(`TMD_DATA_HI_OFF, d); chk16(d, 16'hffff, "data reset");
    rd(8'h0f, b); chk16({8'h00, b}, 16'h0000, "unmapped read");
    chk1(tog | pwm | lvl | ovf | mci, 1'b0, "outputs after reset");
    $display("done: reset");
    for (int i = 0; i < 5; i++) begin
      ctl(i[2:0], 2'h0, 3'b100);
      cyc(divs[i] * 16);
      ctl(3'h7, 2'h0, 3'b000);
      rd16(`TMD_CNT_HI_OFF, c);
      chk1(c >= 16'd14 && c <= 16'd19, 1'b1, "divided count");
    end
    cyc(20);
    rd16(`TMD_CNT_HI_OFF, v); chk16(v, c, "stopped counter");
    ctl(3'h7, 2'h0, 3'b100);
    rd16(`TMD_CNT_HI_OFF, v); chk16(v, 16'h0000, "clear bit");
    rd(`TMD_CONTROL_OFF, b); chk16({8'h00, b}, 16'h00e0, "clear self-resets");
    $display("done: prescaler");
    for (int k = 0; k < 2; k++) begin
      ctl(3'h5 + k[2:0], 2'h0, 3'b100);
      repeat (3 + 2 * k) pulse(0);
      ctl(3'h7, 2'h0, 3'b000);
      rd16(`TMD_CNT_HI_OFF, c);
      chk16(c, 16'(3 + 2 * k), "external edges");
    end
    $display("done: external clock");
    wr(`TMD_PORT2_LOW_CONTROL_REG_OFF, 8'h00);
    wr16(`TMD_DATA_HI_OFF, 16'h1234);
    ctl(3'h7, 2'h1, 3'b010);
    pulse(1);
    rd16(`TMD_DATA_HI_OFF, d); chk16(d, 16'h0005, "rising capture");
    chk1(mci, 1'b1, "capture request");
    rd(`TMD_PEND_OFF, b); chk1(b[3], 1'b1, "pending poll");
    wr(`TMD_PEND_OFF, 8'h00); cyc(2); chk1(mci, 1'b0, "software clear");
    wr16(`TMD_DATA_HI_OFF, 16'h1234);
    ctl(3'h7, 2'h2, 3'b010);
    @(posedge clock) cap_pin <= 1'b1;
    cyc(6);
    rd16(`TMD_DATA_HI_OFF, d); chk16(d, 16'h1234, "rise ignored");
    @(posedge clock) cap_pin <= 1'b0;
    cyc(6);
    rd16(`TMD_DATA_HI_OFF, d); chk16(d, 16'h0005, "falling capture");
    wr(`TMD_PORT2_LOW_CONTROL_REG_OFF, 8'h04);
    wr16(`TMD_DATA_HI_OFF, 16'h1234);
    pulse(1);
    rd16(`TMD_DATA_HI_OFF, d); chk16(d, 16'h1234, "other source");
    wr(`TMD_PORT2_LOW_CONTROL_REG_OFF, 8'h00);
    $display("done: capture");
    wr(`TMD_PEND_OFF, 8'h00);
    lfsr_q = nxt(lfsr_q);
    d = (lfsr_q & 16'h001f) + 16'd3;
    wr16(`TMD_DATA_HI_OFF, d);
    ctl(3'h4, 2'h0, 3'b110);
    wait_tog(n);
    wait_tog(n); chk16(16'(n), d + 16'd1, "interval period");
    chk1(mci & lvl, 1'b1, "match request");
    ctl(3'h7, 2'h0, 3'b010);
    ack(`TMD_VEC_OVF); chk1(mci, 1'b1, "other vector");
    ack(`TMD_VEC_MC); chk1(mci, 1'b1, "masked service");
    wr(`TMD_MASK_OFF, 8'h08);
    ack(`TMD_VEC_MC); chk1(mci | lvl, 1'b0, "unmasked service");
    ctl(3'h4, 2'h0, 3'b100);
    wait_tog(n);
    wait_tog(n); chk1(mci, 1'b0, "match disabled");
    $display("done: interval");
    ctl(3'h7, 2'h3, 3'b000);
    rd16(`TMD_CNT_HI_OFF, c);
    for (int i = 0; i < 8; i++) begin
      lfsr_q = nxt(lfsr_q);
      v = (i == 0) ? c : (i == 1) ? c + 16'd1 : lfsr_q;
      wr16(`TMD_DATA_HI_OFF, v);
      cyc(3);
      chk1(pwm, v > c, "pwm level");
    end
    wr16(`TMD_DATA_HI_OFF, 16'h8000);
    ctl(3'h4, 2'h3, 3'b111);
    n = 0;
    while (ovf !== 1'b1 && n < 70000) begin
      @(posedge clock);
      #1 n++;
    end
    chk1(n >= 65534 && n <= 65540, 1'b1, "pwm wrap period");
    chk1(mci, 1'b1, "pwm match request");
    ack(`TMD_VEC_OVF); chk1(ovf, 1'b0, "overflow service");
    $display("done: pwm");
    final_report();
  end
endmodule
`default_nettype wire

// *** hdl/tmd_edge_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser with rise/fall pulse outputs
module tmd_edge_sync (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic last_q, last_d;

  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // only the second flop and its delayed copy feed the edge logic
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule
`default_nettype wire

// *** hdl/tmd_prescaler.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tmd_regs.svh"
// free-running divider producing one-cycle count ticks
module tmd_prescaler
  import tmd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire tmd_clksel_t clksel,
  input  wire logic        ext_rise,
  input  wire logic        ext_fall,
  output logic             tick
);
  logic [9:0] div_q, div_d;

  always_comb begin
    div_d = div_q + 10'h001;
  end

  always_ff @(posedge clock) begin
    if (rst) div_q <= 10'h000;
    else     div_q <= div_d;
  end

  always_comb begin
    case (clksel)
      TMD_CLK_1024: tick = (div_q & `TMD_DIV1024_M1) == `TMD_DIV1024_M1;
      TMD_CLK_256:  tick = (div_q & `TMD_DIV256_M1) == `TMD_DIV256_M1;
      TMD_CLK_64:   tick = (div_q & `TMD_DIV64_M1) == `TMD_DIV64_M1;
      TMD_CLK_8:    tick = (div_q & `TMD_DIV8_M1) == `TMD_DIV8_M1;
      TMD_CLK_1:    tick = 1'b1;
      TMD_CLK_EXTF: tick = ext_fall;
      TMD_CLK_EXTR: tick = ext_rise;
      default:      tick = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// *** hdl/tmd_timer16.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tmd_regs.svh"
module tmd_timer16
  import tmd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       external_count_clock_pin,
  input  wire logic       capture_input_pin,
  input  wire logic       irq_ack,
  input  wire logic [7:0] irq_ack_vector,
  output logic            toggle_output_pin,
  output logic            pwm_output_pin,
  output logic            shared_irq_level,
  output logic            overflow_irq,
  output logic            match_capture_irq
);
  // ==========================================
  // state
  logic [7:0]  ctrl_q, ctrl_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] data_q, data_d;
  logic [7:0]  data_hi_buf_q, data_hi_buf_d;
  logic        pend_ovf_q, pend_ovf_d;
  logic        pend_mc_q, pend_mc_d;
  logic        mask_q, mask_d;
  logic [7:0]  port2_low_control_reg_q, port2_low_control_reg_d;
  logic        tog_q, tog_d;
  logic        pwm_q, pwm_d;
  logic        lvl_q, lvl_d;
  logic        ovf_irq_q, ovf_irq_d;
  logic        mc_irq_q, mc_irq_d;
  logic [7:0]  rdata_q, rdata_d;

  // ==========================================
  // pin synchronisers and prescaler
  logic ext_rise, ext_fall, cap_rise, cap_fall, tick;
  tmd_clksel_t clksel;
  tmd_mode_t   mode;

  assign clksel = tmd_clksel_t'(ctrl_q[`TMD_CLKSEL_HI:`TMD_CLKSEL_LO]);
  assign mode   = tmd_mode_t'(ctrl_q[`TMD_MODE_HI:`TMD_MODE_LO]);

  tmd_edge_sync u_ext_sync (
    .clock (clock),
    .rst   (rst),
    .pin   (external_count_clock_pin),
    .rise  (ext_rise),
    .fall  (ext_fall)
  );

  tmd_edge_sync u_cap_sync (
    .clock (clock),
    .rst   (rst),
    .pin   (capture_input_pin),
    .rise  (cap_rise),
    .fall  (cap_fall)
  );

  tmd_prescaler u_presc (
    .clock    (clock),
    .rst      (rst),
    .clksel   (clksel),
    .ext_rise (ext_rise),
    .ext_fall (ext_fall),
    .tick     (tick)
  );

  // ==========================================
  // counter, compare, capture
  logic wr_ctrl, wr_clr, is_cap, cap_src_ok, cap_evt, match, ovf, svc_ovf, svc_mc;

  assign wr_ctrl    = reg_wr && (reg_addr == `TMD_CONTROL_OFF);
  assign wr_clr     = wr_ctrl && reg_wdata[`TMD_CLR_BIT];
  assign is_cap     = (mode == TMD_MODE_CAP_RISE) || (mode == TMD_MODE_CAP_FALL);
  assign cap_src_ok = port2_low_control_reg_q[`TMD_CAPSEL_HI:`TMD_CAPSEL_LO] == `TMD_CAPSEL_PIN;
  assign cap_evt    = cap_src_ok && (((mode == TMD_MODE_CAP_RISE) && cap_rise) ||
                                     ((mode == TMD_MODE_CAP_FALL) && cap_fall));
  // match is on the count value held during the tick
  assign match      = tick && (cnt_q == data_q) && !is_cap;
  assign ovf        = tick && (cnt_q == 16'hffff) && !(match && mode == TMD_MODE_INTERVAL);
  assign svc_ovf    = irq_ack && (irq_ack_vector == `TMD_VEC_OVF);
  assign svc_mc     = irq_ack && (irq_ack_vector == `TMD_VEC_MC) && mask_q;

  always_comb begin
    cnt_d = cnt_q;
    if (wr_clr || ctrl_q[`TMD_CLR_BIT]) begin
      cnt_d = 16'h0000;
    end else if (match && mode == TMD_MODE_INTERVAL) begin
      cnt_d = 16'h0000;
    end else if (tick) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_comb begin
    tog_d = tog_q;
    if (match && mode == TMD_MODE_INTERVAL) tog_d = ~tog_q;
    pwm_d = (mode == TMD_MODE_PWM) ? (data_q > cnt_q) : 1'b0;
  end

  // ==========================================
  // register writes and pending flags
  always_comb begin
    ctrl_d        = ctrl_q;
    data_d        = data_q;
    mask_d        = mask_q;
    port2_low_control_reg_d      = port2_low_control_reg_q;
    data_hi_buf_d = data_hi_buf_q;
    if (ctrl_q[`TMD_CLR_BIT]) ctrl_d[`TMD_CLR_BIT] = 1'b0;
    if (reg_wr) begin
      if (reg_addr == `TMD_CONTROL_OFF) begin
        ctrl_d = reg_wdata;
      end else if (reg_addr == `TMD_DATA_HI_OFF) begin
        data_hi_buf_d = reg_wdata;
      end else if (reg_addr == `TMD_DATA_LO_OFF) begin
        data_d = {data_hi_buf_q, reg_wdata};
      end else if (reg_addr == `TMD_MASK_OFF) begin
        mask_d = reg_wdata[`TMD_MASK_LVL_BIT];
      end else if (reg_addr == `TMD_PORT2_LOW_CONTROL_REG_OFF) begin
        port2_low_control_reg_d = reg_wdata;
      end
    end
    if (cap_evt) data_d = cnt_q;
  end

  always_comb begin
    logic wr_pend;
    wr_pend    = reg_wr && (reg_addr == `TMD_PEND_OFF);
    pend_ovf_d = pend_ovf_q;
    pend_mc_d  = pend_mc_q;
    if (svc_ovf || (wr_pend && !reg_wdata[`TMD_PEND_OVF_BIT])) pend_ovf_d = 1'b0;
    if (svc_mc || (wr_pend && !reg_wdata[`TMD_PEND_MC_BIT])) pend_mc_d = 1'b0;
    // a new event wins over a clear in the same cycle
    if (ovf && ctrl_q[`TMD_OVIE_BIT]) pend_ovf_d = 1'b1;
    if ((match || cap_evt) && ctrl_q[`TMD_MCIE_BIT]) pend_mc_d = 1'b1;
    ovf_irq_d = pend_ovf_d;
    mc_irq_d  = pend_mc_d;
    lvl_d     = pend_ovf_d || pend_mc_d;
  end

  // ==========================================
  // read path, registered
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      if (reg_addr == `TMD_CONTROL_OFF)      rdata_d = ctrl_q;
      else if (reg_addr == `TMD_CNT_HI_OFF)  rdata_d = cnt_q[15:8];
      else if (reg_addr == `TMD_CNT_LO_OFF)  rdata_d = cnt_q[7:0];
      else if (reg_addr == `TMD_DATA_HI_OFF) rdata_d = data_q[15:8];
      else if (reg_addr == `TMD_DATA_LO_OFF) rdata_d = data_q[7:0];
      else if (reg_addr == `TMD_PEND_OFF)
        rdata_d = {4'h0, pend_mc_q, pend_ovf_q, 2'h0};
      else if (reg_addr == `TMD_MASK_OFF)    rdata_d = {4'h0, mask_q, 3'h0};
      else if (reg_addr == `TMD_PORT2_LOW_CONTROL_REG_OFF)  rdata_d = port2_low_control_reg_q;
      else                                   rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q        <= `TMD_CONTROL_RST;
      cnt_q         <= 16'h0000;
      data_q        <= 16'hffff;
      data_hi_buf_q <= 8'h00;
      pend_ovf_q    <= 1'b0;
      pend_mc_q     <= 1'b0;
      mask_q        <= 1'b0;
      port2_low_control_reg_q      <= 8'h00;
      tog_q         <= 1'b0;
      pwm_q         <= 1'b0;
      lvl_q         <= 1'b0;
      ovf_irq_q     <= 1'b0;
      mc_irq_q      <= 1'b0;
      rdata_q       <= 8'h00;
    end else begin
      ctrl_q        <= ctrl_d;
      cnt_q         <= cnt_d;
      data_q        <= data_d;
      data_hi_buf_q <= data_hi_buf_d;
      pend_ovf_q    <= pend_ovf_d;
      pend_mc_q     <= pend_mc_d;
      mask_q        <= mask_d;
      port2_low_control_reg_q      <= port2_low_control_reg_d;
      tog_q         <= tog_d;
      pwm_q         <= pwm_d;
      lvl_q         <= lvl_d;
      ovf_irq_q     <= ovf_irq_d;
      mc_irq_q      <= mc_irq_d;
      rdata_q       <= rdata_d;
    end
  end

  assign reg_rdata         = rdata_q;
  assign toggle_output_pin = tog_q;
  assign pwm_output_pin    = pwm_q;
  assign shared_irq_level  = lvl_q;
  assign overflow_irq      = ovf_irq_q;
  assign match_capture_irq = mc_irq_q;

  // ==========================================
  // assertions
  chk_reset_ctrl: assert property (@(posedge clock) $past(rst) |-> ctrl_q == 8'h00)
    else $error("control not zero after reset");
  chk_stop_hold: assert property (@(posedge clock) disable iff (rst)
    (clksel == TMD_CLK_STOP && !wr_clr && !ctrl_q[2] && !cap_evt) |=> cnt_q == $past(cnt_q))
    else $error("counter moved while stopped");
  chk_clear_cnt: assert property (@(posedge clock) disable iff (rst)
    wr_clr |=> cnt_q == 16'h0000 ##1 ctrl_q[2] == 1'b0)
    else $error("clear write did not zero counter");
  chk_clr_selfclr: assert property (@(posedge clock) disable iff (rst)
    ctrl_q[2] && !wr_clr |=> !ctrl_q[2])
    else $error("clear bit did not self clear");
  chk_int_match: assert property (@(posedge clock) disable iff (rst)
    (match && mode == TMD_MODE_INTERVAL && !wr_clr) |=> cnt_q == 16'h0000 && tog_q != $past(tog_q))
    else $error("interval match did not clear and toggle");
  chk_pwm_level: assert property (@(posedge clock) disable iff (rst)
    mode == TMD_MODE_PWM && $stable(mode) |=> pwm_output_pin == ($past(data_q) > $past(cnt_q)))
    else $error("pwm level wrong");
  chk_cap_load: assert property (@(posedge clock) disable iff (rst)
    cap_evt |=> data_q == $past(cnt_q))
    else $error("capture did not load counter");
  chk_mc_pend: assert property (@(posedge clock) disable iff (rst)
    (cap_evt || match) && ctrl_q[1] |=> pend_mc_q && match_capture_irq)
    else $error("match pending not set");
  chk_ovf_pend: assert property (@(posedge clock) disable iff (rst)
    ovf && ctrl_q[0] |=> pend_ovf_q && shared_irq_level)
    else $error("overflow pending not set");
  chk_ovf_off: assert property (@(posedge clock) disable iff (rst)
    !pend_ovf_q && !(ovf && ctrl_q[0]) |=> !pend_ovf_q)
    else $error("overflow pending set without cause");
  cov_interval: cover property (@(posedge clock) match && mode == TMD_MODE_INTERVAL);
  cov_pwm_wrap: cover property (@(posedge clock) ovf && mode == TMD_MODE_PWM);
  cov_capture:  cover property (@(posedge clock) cap_evt);
endmodule
`default_nettype wire

// *** include/tmd_pkg.sv ***
package tmd_pkg;
  typedef enum logic [2:0] {
    TMD_CLK_1024 = 3'h0,
    TMD_CLK_256  = 3'h1,
    TMD_CLK_64   = 3'h2,
    TMD_CLK_8    = 3'h3,
    TMD_CLK_1    = 3'h4,
    TMD_CLK_EXTF = 3'h5,
    TMD_CLK_EXTR = 3'h6,
    TMD_CLK_STOP = 3'h7
  } tmd_clksel_t;
  typedef enum logic [1:0] {
    TMD_MODE_INTERVAL = 2'h0,
    TMD_MODE_CAP_RISE = 2'h1,
    TMD_MODE_CAP_FALL = 2'h2,
    TMD_MODE_PWM      = 2'h3
  } tmd_mode_t;
endpackage

// *** include/tmd_regs.svh ***
`ifndef TMD_REGS_SVH
`define TMD_REGS_SVH
// ==========================================
// register offsets (8-bit register file)
`define TMD_CONTROL_OFF   8'h01
`define TMD_CNT_HI_OFF    8'h02
`define TMD_CNT_LO_OFF    8'h03
`define TMD_DATA_HI_OFF   8'h04
`define TMD_DATA_LO_OFF   8'h05
`define TMD_PEND_OFF      8'h06
`define TMD_MASK_OFF      8'h07
`define TMD_PORT2_LOW_CONTROL_REG_OFF    8'h08
// ==========================================
// control, pending, mask and capture-select field positions
`define TMD_CLKSEL_HI     7
`define TMD_CLKSEL_LO     5
`define TMD_MODE_HI       4
`define TMD_MODE_LO       3
`define TMD_CLR_BIT       2
`define TMD_MCIE_BIT      1
`define TMD_OVIE_BIT      0
`define TMD_PEND_OVF_BIT  2
`define TMD_PEND_MC_BIT   3
`define TMD_MASK_LVL_BIT  3
`define TMD_CAPSEL_HI     3
`define TMD_CAPSEL_LO     2
// ==========================================
// reset values, vectors and capture-pin select code
`define TMD_CONTROL_RST   8'h00
`define TMD_VEC_OVF       8'hda
`define TMD_VEC_MC        8'hd8
`define TMD_CAPSEL_PIN    2'h0
// ==========================================
// prescaler taps (divide ratio minus one)
`define TMD_DIV1024_M1    10'h3ff
`define TMD_DIV256_M1     10'h0ff
`define TMD_DIV64_M1      10'h03f
`define TMD_DIV8_M1       10'h007
`endif
